// *** digi_consts.svh ***
// timing counts, strap addresses and sizes of the pixel output block
// assumes: included by bare name, core clock at 25 MHz
`ifndef DIGI_CONSTS_SVH
`define DIGI_CONSTS_SVH

// core clock period in ns
`define CLK_NS 40
// core clocks per pixel sample; half a pixel is one clock
`define PIX_DIV 2
// bus target address for strap low / high
`define ADDR_STRAP_LOW 7'h4c
`define ADDR_STRAP_HIGH 7'h4d
// width of the regenerated aligned line sync pulse
`define HS_PULSE_NS 320
`define HS_PULSE_CYC ((`HS_PULSE_NS) / (`CLK_NS))
// a sync pulse longer than this breaks the line pattern
`define BROAD_NS 2560
`define BROAD_CYC ((`BROAD_NS) / (`CLK_NS))
// sample buffer depth in words
`define FIFO_DEPTH 32

`endif

// *** digi_pkg.sv ***
// types shared by the pixel output block, its receiver model and the bench
// assumes: compiled before every design file
package digi_pkg;

    // one pixel word with the line sync that belongs to it
    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
        logic       line_sync;
    } pixel_word_t;

    // handover of one word into the output clock domain
    typedef enum logic [1:0] {
        XFER_IDLE = 2'b01,
        XFER_WAIT = 2'b10
    } xfer_state_t;

    // core clock domain state
    typedef struct packed {
        logic [1:0]  inv_sync;
        logic [1:0]  hs_sync;
        logic [1:0]  sog_sync;
        logic [1:0]  vs_sync;
        logic [1:0]  strap_sync;
        logic [1:0]  ack_sync;
        logic        phase;
        logic        req;
        xfer_state_t xfer;
        pixel_word_t hold;
        logic        sync_prev;
        logic [15:0] since_edge;
        logic [15:0] period;
        logic [7:0]  hs_left;
        logic [7:0]  width;
        logic        disrupted;
        logic        line_buf;
        logic        frame_buf;
        logic [6:0]  address;
        logic        strap_done;
    } core_state_t;

    // output clock domain state
    typedef struct packed {
        logic [1:0]  req_sync;
        logic        ack;
        pixel_word_t out;
        logic        out_valid;
    } pix_state_t;

endpackage

// *** sample_fifo.sv ***
// synchronous sample buffer with valid/ready on both sides
// assumes: one clock, async active-low reset, power-of-two depth
`timescale 1ns/1ps
`include "digi_consts.svh"
module sample_fifo #(
    parameter int WIDTH = 25,
    parameter int DEPTH = `FIFO_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wr;
        logic [AW:0]                 rd;
    } fifo_state_t;

    fifo_state_t st;
    fifo_state_t next_st;

    // ***************************************
    // elaboration check
    // ***************************************
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : bad_size
        $error("sample_fifo needs a power-of-two depth of at least 2");
    end

    // ***************************************
    // flags and read port
    // ***************************************
    // extra pointer bit tells full from empty
    assign in_ready  = !((st.wr[AW] != st.rd[AW]) && (st.wr[AW-1:0] == st.rd[AW-1:0]));
    assign out_valid = (st.wr != st.rd);
    assign out_data  = st.mem[st.rd[AW-1:0]]; // storage cells are flip-flops

    // next state
    always_comb begin
        next_st = st;
        if (in_valid && in_ready) begin
            next_st.mem[st.wr[AW-1:0]] = in_data;
            next_st.wr = st.wr + 1'b1;
        end
        if (out_valid && out_ready) begin
            next_st.rd = st.rd + 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    chk_full_blocks : assert property (@(posedge clk) disable iff (!rstn)
        !in_ready |=> $stable(st.wr))
        else $error("write pointer moved while full");

endmodule // sample_fifo

// *** pixel_output.sv ***
// pixel output stage of a three-channel video digitizer: sampling phase,
// sync processing, sample buffer and forwarded pixel clock
// assumes: adc words and use_green_sync/composite_sync come from clk-domain
// logic; sync pins and straps are asynchronous; pix_clk runs free
`timescale 1ns/1ps
`include "digi_consts.svh"
module pixel_output #(
    parameter int DEPTH = `FIFO_DEPTH
) (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       pix_clk,
    input  wire logic       sample_phase_invert,
    input  wire logic       bus_address_strap,
    input  wire logic       line_sync_input,
    input  wire logic       green_sync_input,
    input  wire logic       frame_sync_input,
    input  wire logic       use_green_sync,
    input  wire logic       composite_sync,
    input  wire logic [7:0] adc_red,
    input  wire logic [7:0] adc_green,
    input  wire logic [7:0] adc_blue,
    output logic            sample_ready,
    output logic [7:0]      red_pixel_bits,
    output logic [7:0]      green_pixel_bits,
    output logic [7:0]      blue_pixel_bits,
    output logic            pixel_out_valid,
    output logic            pixel_out_clock,
    output logic            pixel_out_clock_inv,
    output logic            aligned_line_sync,
    output logic            buffered_line_sync,
    output logic            buffered_frame_sync,
    output logic [6:0]      bus_target_address
);

    localparam logic [7:0] HS_PULSE = 8'(`HS_PULSE_CYC);
    localparam logic [7:0] BROAD    = 8'(`BROAD_CYC);

    // ***************************************
    // elaboration check
    // ***************************************
    if (`PIX_DIV != 2) begin : bad_div
        $error("half-pixel shift needs exactly two clocks per pixel");
    end

    digi_pkg::core_state_t st;
    digi_pkg::core_state_t next_st;
    digi_pkg::pix_state_t  ps;
    digi_pkg::pix_state_t  next_ps;

    logic                  strobe;
    logic                  sel_level;
    logic                  rise;
    logic                  accept;
    digi_pkg::pixel_word_t sample;
    logic                  fifo_out_valid;
    logic                  fifo_out_ready;
    digi_pkg::pixel_word_t fifo_out_data;

    // ***************************************
    // sampling and sync selection
    // ***************************************
    // phase select
    // the sample lands on the other clock of the pixel pair
    assign strobe    = (st.phase != st.inv_sync[1]);
    assign sel_level = use_green_sync ? st.sog_sync[1] : st.hs_sync[1];
    assign rise      = sel_level && !st.sync_prev;
    // period gate
    // edges closer than half a line are equalising or serration pulses
    assign accept    = rise && (st.since_edge >= {1'b0, st.period[15:1]});

    assign sample = '{red:       adc_red,
                      green:     adc_green,
                      blue:      adc_blue,
                      line_sync: (st.hs_left != 8'h00)};

    // ***************************************
    // sample buffer
    // ***************************************
    // full buffer drops the strobe; sample_ready shows it to the source
    sample_fifo #(
        .WIDTH ($bits(digi_pkg::pixel_word_t)),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rstn      (rstn),
        .in_valid  (strobe),
        .in_ready  (sample_ready),
        .in_data   (sample),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    assign fifo_out_ready = (st.xfer == digi_pkg::XFER_IDLE);

    // ***************************************
    // core domain next state
    // ***************************************
    always_comb begin
        next_st = st;
        // two flip-flop synchronisers on every pin
        next_st.inv_sync   = {st.inv_sync[0], sample_phase_invert};
        next_st.hs_sync    = {st.hs_sync[0], line_sync_input};
        next_st.sog_sync   = {st.sog_sync[0], green_sync_input};
        next_st.vs_sync    = {st.vs_sync[0], frame_sync_input};
        next_st.strap_sync = {st.strap_sync[0], bus_address_strap};
        next_st.ack_sync   = {st.ack_sync[0], ps.ack};
        next_st.phase      = !st.phase;
        next_st.sync_prev  = sel_level;

        // strap capture
        // waits for the third edge after release so the synchroniser holds
        // the pin; since_edge cannot be cleared before then, later moves ignored
        if (!st.strap_done && st.since_edge >= 16'h0002) begin
            next_st.address    = st.strap_sync[1] ? `ADDR_STRAP_HIGH : `ADDR_STRAP_LOW;
            next_st.strap_done = 1'b1;
        end

        if (st.since_edge != 16'hffff) begin
            next_st.since_edge = st.since_edge + 16'h0001;
        end
        if (st.hs_left != 8'h00) begin
            next_st.hs_left = st.hs_left - 8'h01;
        end
        if (accept) begin
            next_st.period     = st.since_edge;
            next_st.since_edge = 16'h0000;
            next_st.hs_left    = HS_PULSE;
        end

        // disruption detect
        // broad pulse or a double-rate edge marks the frame interval
        if (sel_level) begin
            if (st.width != BROAD) begin
                next_st.width = st.width + 8'h01;
            end else begin
                next_st.disrupted = 1'b1;
            end
        end else begin
            if (st.sync_prev && st.width != BROAD) begin
                next_st.disrupted = 1'b0;
            end
            next_st.width = 8'h00;
        end
        if (rise && !accept) begin
            next_st.disrupted = 1'b1;
        end

        next_st.line_buf  = sel_level;
        next_st.frame_buf = composite_sync ? st.disrupted : st.vs_sync[1];

        // word handover: toggle request, wait for the echo
        unique case (st.xfer)
            digi_pkg::XFER_IDLE: begin
                if (fifo_out_valid) begin
                    next_st.hold = fifo_out_data;
                    next_st.req  = !st.req;
                    next_st.xfer = digi_pkg::XFER_WAIT;
                end
            end
            digi_pkg::XFER_WAIT: begin
                if (st.ack_sync[1] == st.req) begin
                    next_st.xfer = digi_pkg::XFER_IDLE;
                end
            end
            default: begin
                next_st.xfer = digi_pkg::XFER_IDLE;
            end
        endcase
    end

    // core domain state register
    // external reset pulse
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st         <= '0;
            st.xfer    <= digi_pkg::XFER_IDLE;
            st.address <= `ADDR_STRAP_LOW;
        end else begin
            st <= next_st;
        end
    end

    // ***************************************
    // output clock domain
    // ***************************************
    // hold is stable from the request toggle until the echo returns,
    // so sampling it after two synchroniser stages is safe
    always_comb begin
        next_ps           = ps;
        next_ps.req_sync  = {ps.req_sync[0], st.req};
        next_ps.out_valid = 1'b0;
        if (ps.req_sync[1] != ps.ack) begin
            next_ps.out       = st.hold;
            next_ps.ack       = ps.req_sync[1];
            next_ps.out_valid = 1'b1;
        end
    end

    // reset asserts async; release is harmless as nothing moves until a request
    always_ff @(posedge pix_clk or negedge rstn) begin
        if (!rstn) begin
            ps <= '0;
        end else begin
            ps <= next_ps;
        end
    end

    // ***************************************
    // outputs
    // ***************************************
    // launch edge
    // data launch on pix_clk rise, forwarded rise lands mid-word
    assign pixel_out_clock     = !pix_clk;
    assign pixel_out_clock_inv = pix_clk;
    assign red_pixel_bits      = ps.out.red;
    assign green_pixel_bits    = ps.out.green;
    assign blue_pixel_bits     = ps.out.blue;
    assign aligned_line_sync   = ps.out.line_sync;
    assign pixel_out_valid     = ps.out_valid;
    assign buffered_line_sync  = st.line_buf;
    assign buffered_frame_sync = st.frame_buf;
    assign bus_target_address  = st.address;

    // ***************************************
    // assertions
    // ***************************************
    chk_phase_shift : assert property (
        @(posedge clk) disable iff (!rstn)
        strobe ##1 $stable(st.inv_sync[1]) |-> !strobe ##1 (strobe || $changed(st.inv_sync[1])))
        else $error("sample strobe not one per pixel");

    // an invert change moves the strobe by one clock: a doubled or skipped slot
    chk_phase_invert : assert property (
        @(posedge clk) disable iff (!rstn)
        $changed(st.inv_sync[1]) |-> (strobe == $past(strobe)))
        else $error("sample taken on wrong half pixel");

    chk_strap_address : assert property (
        @(posedge clk) disable iff (!rstn)
        $rose(st.strap_done) |-> bus_target_address ==
            ($past(st.strap_sync[1]) ? `ADDR_STRAP_HIGH : `ADDR_STRAP_LOW))
        else $error("bus address does not match strap");

    chk_word_rate : assert property (
        @(posedge pix_clk) disable iff (!rstn)
        pixel_out_valid |=> !pixel_out_valid ##1 !pixel_out_valid)
        else $error("words closer than the handover allows");

    chk_clock_pair : assert property (
        @(posedge clk) disable iff (!rstn)
        pixel_out_clock_inv == !pixel_out_clock)
        else $error("clock outputs not complementary");

    chk_data_hold : assert property (
        @(posedge pix_clk) disable iff (!rstn)
        !pixel_out_valid |-> $stable({red_pixel_bits, green_pixel_bits, blue_pixel_bits}))
        else $error("pixel words changed without a new word");

    chk_sync_aligned : assert property (
        @(posedge pix_clk) disable iff (!rstn)
        !pixel_out_valid |-> $stable(aligned_line_sync))
        else $error("aligned sync moved apart from data");

    chk_hs_pulse : assert property (
        @(posedge clk) disable iff (!rstn)
        accept |=> (st.hs_left != 8'h00) [*8] ##1 (st.hs_left == 8'h00 || $past(accept)))
        else $error("regenerated line pulse has wrong width");

    chk_line_buffer : assert property (
        @(posedge clk) disable iff (!rstn)
        ##1 buffered_line_sync == $past(sel_level))
        else $error("buffered line sync not a copy of the source");

    chk_frame_follow : assert property (
        @(posedge clk) disable iff (!rstn)
        !composite_sync ##1 !composite_sync |-> buffered_frame_sync == $past(st.vs_sync[1]))
        else $error("frame sync does not follow its input");

    chk_frame_broad : assert property (
        @(posedge clk) disable iff (!rstn)
        composite_sync && sel_level && st.width == BROAD && $stable(composite_sync)
            |=> ##1 buffered_frame_sync || !composite_sync)
        else $error("broad pulse did not raise frame sync");

    chk_launch_edge : assert property (
        @(posedge pix_clk) disable iff (!rstn)
        pixel_out_valid |-> pixel_out_clock && !pixel_out_clock_inv)
        else $error("data launched near forwarded clock rise");

    cov_word_out : cover property (@(posedge pix_clk) disable iff (!rstn) pixel_out_valid);
    cov_inverted : cover property (@(posedge clk) disable iff (!rstn) strobe && st.inv_sync[1]);
    cov_disrupted : cover property (@(posedge clk) disable iff (!rstn) composite_sync && $rose(st.frame_buf));
    cov_fifo_full : cover property (@(posedge clk) disable iff (!rstn) !sample_ready);

endmodule // pixel_output

// *** pixel_rx_model.sv ***
// model of the downstream video logic that takes the pixel words
// assumes: pixel_out_valid spans one pix cycle around a rising forwarded clock
`timescale 1ns/1ps
module pixel_rx_model (
    input  wire logic             pixel_out_clock,
    input  wire logic             pixel_out_valid,
    input  wire logic [7:0]       red_pixel_bits,
    input  wire logic [7:0]       green_pixel_bits,
    input  wire logic [7:0]       blue_pixel_bits,
    input  wire logic             aligned_line_sync,
    output digi_pkg::pixel_word_t cap_word,
    output logic                  cap_toggle
);
    // toggle rather than pulse so the bench never misses a word
    initial cap_toggle = 1'b0;
    always @(posedge pixel_out_clock) begin
        if (pixel_out_valid === 1'b1) begin
            cap_word   <= {red_pixel_bits, green_pixel_bits, blue_pixel_bits, aligned_line_sync};
            cap_toggle <= ~cap_toggle;
        end
    end
endmodule // pixel_rx_model

// *** test_pixel_output.sv ***
// self-checking bench of the pixel output stage
// assumes: core clock 40 ns, pixel clock 32 ns free running, no back-pressure
`timescale 1ns/1ps
module test_pixel_output;
    // ****************************************
    // signals
    // ****************************************
    logic                  clk, rstn, pix_clk, sample_phase_invert, bus_address_strap;
    logic                  line_sync_input, green_sync_input, frame_sync_input;
    logic                  use_green_sync, composite_sync;
    logic [7:0]            adc_red, adc_green, adc_blue;
    logic                  sample_ready, pixel_out_valid, pixel_out_clock, pixel_out_clock_inv;
    logic [7:0]            red_pixel_bits, green_pixel_bits, blue_pixel_bits;
    logic                  aligned_line_sync, buffered_line_sync, buffered_frame_sync;
    logic [6:0]            bus_target_address;
    digi_pkg::pixel_word_t rx_word;
    logic                  rx_toggle, half, seen_full, started;
    logic [16:0]           lf;
    logic [23:0]           sent[$];
    int                    n_mismatch, checked, al_cnt, n_rise;
    time                   t0;

    pixel_output #(.DEPTH(32)) dut_u (.clk(clk), .rstn(rstn), .pix_clk(pix_clk),
        .sample_phase_invert(sample_phase_invert), .bus_address_strap(bus_address_strap),
        .line_sync_input(line_sync_input), .green_sync_input(green_sync_input),
        .frame_sync_input(frame_sync_input), .use_green_sync(use_green_sync),
        .composite_sync(composite_sync), .adc_red(adc_red), .adc_green(adc_green),
        .adc_blue(adc_blue), .sample_ready(sample_ready), .red_pixel_bits(red_pixel_bits),
        .green_pixel_bits(green_pixel_bits), .blue_pixel_bits(blue_pixel_bits),
        .pixel_out_valid(pixel_out_valid), .pixel_out_clock(pixel_out_clock),
        .pixel_out_clock_inv(pixel_out_clock_inv), .aligned_line_sync(aligned_line_sync),
        .buffered_line_sync(buffered_line_sync), .buffered_frame_sync(buffered_frame_sync),
        .bus_target_address(bus_target_address));

    pixel_rx_model rx_u (.pixel_out_clock(pixel_out_clock), .pixel_out_valid(pixel_out_valid),
        .red_pixel_bits(red_pixel_bits), .green_pixel_bits(green_pixel_bits),
        .blue_pixel_bits(blue_pixel_bits), .aligned_line_sync(aligned_line_sync),
        .cap_word(rx_word), .cap_toggle(rx_toggle));

    // clocks; the pixel clock is offset and faster so the domains drift apart
    initial clk = 1'b0;
    always #20 clk = ~clk;
    initial begin
        pix_clk = 1'b0;
        #7;
        forever #16 pix_clk = ~pix_clk;
    end

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [16:0] lfsr_next(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction

    task automatic clks(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // words must leave in order; dropped or doubled samples are allowed
    task automatic check_word(input logic [23:0] w);
        int j;
        j = 0;
        checked++;
        while (j < sent.size() && sent[j] !== w) j++;
        if (j == sent.size()) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, w, sent[0]);
        end else begin
            repeat (j) void'(sent.pop_front());
        end
    endtask

    task automatic set_src(input logic v);
        if (v && !(use_green_sync ? green_sync_input : line_sync_input)) n_rise++;
        if (use_green_sync) green_sync_input = v;
        else line_sync_input = v;
    endtask

    task automatic finish_test();
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // random samples, each held two core clocks so any strobe phase takes it
    always @(negedge clk) begin
        half = ~half;
        if (sample_ready === 1'b0) seen_full = 1'b1;
        if (half) begin
            lf = lfsr_next(lf);
            {adc_red, adc_green, adc_blue} = {lf[7:0], lf[15:8], lf[16:9]};
            sent.push_back({adc_red, adc_green, adc_blue});
        end
    end

    // every captured word is checked against the sent stream
    always @(rx_toggle) begin
        if (started) begin
            if (rx_word.line_sync === 1'b1) al_cnt++;
            check_word(rx_word[24:1]);
        end
    end

    // watchdog well beyond the expected 3000 core clocks
    initial begin
        #1000000;
        n_mismatch++;
        finish_test();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {rstn, sample_phase_invert, bus_address_strap, line_sync_input, green_sync_input} = 5'h00;
        {frame_sync_input, use_green_sync, composite_sync, half, seen_full, started} = 6'h00;
        {adc_red, adc_green, adc_blue} = 24'h000000;
        lf = 17'h18498;
        sent.push_back(24'h000000);
        clks(25);
        rstn = 1'b1;
        started = 1'b1;
        clks(5);
        cmp_val({1'b0, bus_target_address}, 8'h4c);
        @(posedge pixel_out_clock) t0 = $time;
        @(posedge pixel_out_clock);
        cmp_val(8'($time - t0), 8'h20);
        for (int i = 0; i < 8; i++) begin
            #13;
            cmp_val({7'h00, pixel_out_clock_inv}, {7'h00, ~pixel_out_clock});
        end
        // selected source reaches the buffered line sync, the other does not
        for (int s = 0; s < 2; s++) begin
            @(negedge clk) use_green_sync = s[0];
            {line_sync_input, green_sync_input} = s[0] ? 2'b01 : 2'b10;
            clks(5);
            cmp_val({7'h00, buffered_line_sync}, 8'h01);
            {line_sync_input, green_sync_input} = s[0] ? 2'b10 : 2'b01;
            clks(5);
            cmp_val({7'h00, buffered_line_sync}, 8'h00);
        end
        {line_sync_input, green_sync_input} = 2'b00;
        // two selected rises above may each start an aligned pulse too
        n_rise = n_rise + 2;
        frame_sync_input = 1'b1;
        clks(5);
        cmp_val({7'h00, buffered_frame_sync}, 8'h01);
        frame_sync_input = 1'b0;
        clks(5);
        cmp_val({7'h00, buffered_frame_sync}, 8'h00);
        // composite lines at a steady spacing with one broad pulse
        composite_sync = 1'b1;
        for (int i = 0; i < 5; i++) begin
            set_src(1'b1);
            clks(i == 2 ? 100 : 10);
            if (i == 2) cmp_val({7'h00, buffered_frame_sync}, 8'h01);
            set_src(1'b0);
            clks(i == 2 ? 300 : 390);
            if (i == 3) cmp_val({7'h00, buffered_frame_sync}, 8'h00);
        end
        for (int i = 0; i < 4; i++) begin
            sample_phase_invert = ~sample_phase_invert;
            clks(200);
        end
        cmp_val({7'h00, seen_full}, 8'h01);
        cmp_val({7'h00, al_cnt > 0}, 8'h01);
        cmp_val({7'h00, al_cnt <= 4 * n_rise}, 8'h01);
        // second reset with the strap high, later strap changes ignored
        rstn = 1'b0;
        bus_address_strap = 1'b1;
        clks(25);
        rstn = 1'b1;
        clks(5);
        cmp_val({1'b0, bus_target_address}, 8'h4d);
        bus_address_strap = 1'b0;
        clks(10);
        cmp_val({1'b0, bus_target_address}, 8'h4d);
        clks(100);
        finish_test();
    end
endmodule // test_pixel_output
